// [hdl/granule_mask.sv]
/*
 turns the effective length_code into a mask of accessible 128-bit
 granules and flags granules that become accessible again.
 assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none

module granule_mask (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // effective length and refill policy
    input wire logic [vlen_pkg::CODE_W-1:0] eff_code,
    input wire logic fill_zero,
    // granule controls
    output logic [vlen_pkg::GRAN_N-1:0] gran_enable,
    output logic [vlen_pkg::GRAN_N-1:0] gran_zero
);
    import vlen_pkg::*;

    wire logic [GRAN_N-1:0] next_gran_enable;  // thermometer mask
    wire logic [GRAN_N-1:0] exposed;           // granules turning on

    // granule g is live while g is not above the code
    genvar g;
    generate
        for (g = 0; g < GRAN_N; g++) begin : g_therm
            assign next_gran_enable[g] = (g <= int'(eff_code));
        end
    endgenerate

    assign exposed = next_gran_enable & ~gran_enable;

    // mask and one-cycle zero request for newly exposed granules
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            gran_enable <= '1;
            gran_zero <= '0;
        end else begin
            gran_enable <= next_gran_enable;
            gran_zero <= fill_zero ? exposed : '0;
        end
    end

endmodule : granule_mask
`default_nettype wire

// [hdl/length_rounder.sv]
/*
 rounds one requested length_code down to a supported length.
 assumes codes count 128-bit steps minus one; purely combinational.
*/
`timescale 1ns/100ps
`default_nettype none

module length_rounder #(
    parameter int MAX_CODE = 15,
    parameter logic [15:0] OPT_MASK = 16'h0000
) (
    // request and result
    input wire logic [vlen_pkg::CODE_W-1:0] req_code,
    output logic [vlen_pkg::CODE_W-1:0] round_code
);
    import vlen_pkg::*;

    // a code is supported if it is the maximum, a power of two minus one
    // below it, or an optional step chosen at build time
    function automatic logic supported(input int c);
        logic pow2;
        pow2 = (((c + 1) & c) == 0);
        return (c == MAX_CODE) || (c < MAX_CODE && (pow2 || OPT_MASK[c]));
    endfunction : supported

    // largest supported code not above the capped request
    always_comb begin
        round_code = '0;
        for (int c = 0; c < GRAN_N; c++) begin
            if (c <= int'(req_code) && supported(c)) begin
                round_code = CODE_W'(c);
            end
        end
    end

endmodule : length_rounder
`default_nettype wire

// [hdl/vector_length_limiter.sv]
/*
 vector length limiter: holds the per-level length limits and the
 level controls behind an apb slave, works out the effective vector
 length at the current level, drives the accessible granule mask,
 reports trapped vector use in a syndrome register and raises an
 interrupt on traps and on length changes.
 register map, one word each:
   0x00 0x04 0x08 limits, levels 1..3
   0x0c control, 0x10 status
   0x14 syndrome, 0x18 events
   0x1c event mask
 control: [1:0] level, [7:4] vector off,
   [11:8] 32-bit state, [15:12] fp off,
   [16] zero fill
 spare bits read zero.
 lengths count 128-bit steps.
 no wait states; read data taken in setup.
 refused accesses get pslverr, zero data.
 effective code: smallest rounded limit
 of this level and those above it.
 a disabled level 1..3 counts as code 0.
 assumes apb signals and the core pulse are on sys_clk.
 assumes software keeps the level field
 in step with the core.
 vec_insn_attempt: one pulse per attempt.

 // Operation
 // - each level limit caps itself and below
 // - limit is (length_code plus one) times 128
 // - powers of two below maximum always supported
 // - required lengths derive from implemented maximum
 // - unsupported request rounds down to supported
 // - stored length_code reads back as written
 // - bits above limited length made inaccessible
 // - re-exposed bits give zero or old value
 // - disabled, trapped or 32-bit level uses 128
 // - preserve state when lower levels all off
 // - limit writes seen by next use immediately
 // - trapped access reports class 0b011001
*/
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module vector_length_limiter #(
    parameter int MAX_CODE = 15,              // 2048-bit maximum
    parameter logic [15:0] OPT_MASK = 16'h0000 // optional lengths
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core side
    input wire logic vec_insn_attempt,
    output logic [vlen_pkg::CODE_W-1:0] eff_length_code,
    output logic [vlen_pkg::GRAN_N-1:0] gran_enable,
    output logic [vlen_pkg::GRAN_N-1:0] gran_zero,
    output logic state_preserve,
    // interrupt
    output logic irq
);
    import vlen_pkg::*;

    // stored limits, index 1..3 used, read back unaltered
    // held in flops, read straight
    // by the rounders every cycle
    logic [CODE_W-1:0] limit [1:LVL_N-1];
    ctrl_s ctrl;                           // level controls
    syndrome_s syndrome;                   // last trap record
    logic [IRQ_W-1:0] int_status;          // sticky events
    logic [IRQ_W-1:0] int_mask;            // event enables
    logic [CODE_W-1:0] eff_prev;           // last effective code

    // address decode, shared by read and write paths
    // code 0: unmapped offset,
    // answered pslverr, zero data
    function automatic logic [3:0] decode(input logic [7:0] a);
        case (a)
            OFS_LIMIT_EL1: return 4'h1;
            OFS_LIMIT_EL2: return 4'h2;
            OFS_LIMIT_EL3: return 4'h3;
            OFS_CTRL: return 4'h4;
            OFS_STATUS: return 4'h5;
            OFS_SYNDROME: return 4'h6;
            OFS_INT_STATUS: return 4'h7;
            OFS_INT_MASK: return 4'h8;
            default: return 4'h0;
        endcase
    endfunction : decode

    // bus phases
    // pready is combinational;
    // all answers are settled early
    wire logic setup_phase;                // first cycle of transfer
    wire logic access_phase;               // completing cycle
    wire logic [3:0] sel;                  // decoded register
    wire logic is_limit;                   // a limit register
    wire logic limit_trap;                 // limit access trapped
    wire logic wr_ok;                      // write may land

    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;
    assign sel = decode(paddr);
    // limit offsets share one trap check
    assign is_limit = (sel == 4'h1) || (sel == 4'h2) || (sel == 4'h3);

    // zero-wait slave: data prepared in setup, pready in access
    // data captured one cycle early
    // keeps decode off the answer path;
    // status reads show the setup cycle
    assign pready = access_phase;

    // per-level effective codes
    // level 0 has no limit of its own,
    // only the levels above bound it
    wire logic [CODE_W-1:0] rounded [1:LVL_N-1]; // after rounding
    wire logic [CODE_W-1:0] level_eff [1:LVL_N-1];
    wire logic [LVL_N-1:0] level_off;            // vector unusable

    // a level is unusable when disabled, trapped or 32-bit
    // bits written by software only
    assign level_off = ctrl.vec_off | ctrl.narrow;

    // trap on vector use or limit access at an unusable level
    // a trapped write is dropped
    // before the limit flops, so the
    // stored code never sees it
    wire logic cur_off;
    assign cur_off = level_off[ctrl.level];
    assign limit_trap = access_phase && is_limit && cur_off;
    assign wr_ok = access_phase && pwrite && !limit_trap;

    // one rounder per level, all live,
    // so a level change only needs
    // a new minimum, no wait state
    genvar lv;
    generate
        for (lv = 1; lv < LVL_N; lv++) begin : g_level
            // each stored limit rounded down to a supported step
            length_rounder #(
                .MAX_CODE(MAX_CODE),
                .OPT_MASK(OPT_MASK)
            ) u_round (
                .req_code(limit[lv]),
                .round_code(rounded[lv])
            );
            // unusable level counts as code 0, except on read
            assign level_eff[lv] = level_off[lv] ? '0 : rounded[lv];
        end
    endgenerate

    // minimum over current level and every level above it
    // starts at the maximum, which caps
    // requests above it; a disabled
    // level pulls it to code 0
    logic [CODE_W-1:0] next_eff;
    always_comb begin
        next_eff = CODE_W'(MAX_CODE);
        for (int l = 1; l < LVL_N; l++) begin
            // a limit binds its own level and all below
            if (l >= int'(ctrl.level) && level_eff[l] < next_eff) begin
                next_eff = level_eff[l];
            end
        end
    end

    // limits are read straight from the flops, so a write is seen
    // by the very next use without any synchronising step
    // limitation: combinational output,
    // register it if needed early
    assign eff_length_code = next_eff;

    // state preserved when fp and vector are off at all levels below
    // at level 0 nothing lies below,
    // so the flag reads one there
    logic preserve_c;
    always_comb begin
        preserve_c = 1'b1;
        for (int l = 0; l < LVL_N; l++) begin
            // only levels below count
            if (l < int'(ctrl.level)) begin
                preserve_c = preserve_c && ctrl.fp_off[l] && level_off[l];
            end
        end
    end
    assign state_preserve = preserve_c;

    // granule mask with refill control
    // mask lags the code one cycle;
    // a granule turning on again gets
    // a zero pulse if fill_zero is set,
    // otherwise it keeps its old bits
    granule_mask u_mask (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .eff_code(next_eff),
        .fill_zero(ctrl.fill_zero),
        .gran_enable(gran_enable),
        .gran_zero(gran_zero)
    );

    // events
    // length event compares with last
    // cycle's code: fires in the cycle
    // the code moves
    wire logic trap_evt;                   // trapped vector use
    wire logic len_evt;                    // effective length moved
    wire logic [IRQ_W-1:0] evt;
    wire logic [IRQ_W-1:0] w1c;            // clears from software

    assign trap_evt = (vec_insn_attempt && cur_off) || limit_trap;
    assign len_evt = (next_eff != eff_prev);
    assign evt = {len_evt, trap_evt};
    // only the event register clears
    assign w1c = (wr_ok && sel == 4'h7) ? pwdata[IRQ_W-1:0] : '0;
    // level output, unmasked events
    assign irq = |(int_status & int_mask);

    // read mux, registered in the setup cycle
    // limits read back as stored,
    // never as rounded
    logic [31:0] rd_word;
    always_comb begin
        rd_word = '0;
        case (sel)
            4'h1: rd_word[CODE_W-1:0] = limit[1];
            4'h2: rd_word[CODE_W-1:0] = limit[2];
            4'h3: rd_word[CODE_W-1:0] = limit[3];
            4'h4: begin
                rd_word[CTRL_LEVEL_LSB +: 2] = ctrl.level;
                rd_word[CTRL_VEC_OFF_LSB +: LVL_N] = ctrl.vec_off;
                rd_word[CTRL_NARROW_LSB +: LVL_N] = ctrl.narrow;
                rd_word[CTRL_FP_OFF_LSB +: LVL_N] = ctrl.fp_off;
                rd_word[CTRL_FILL_ZERO_BIT] = ctrl.fill_zero;
            end
            // status is read only
            4'h5: begin
                rd_word[CODE_W-1:0] = next_eff;
                rd_word[STAT_PRESERVE_BIT] = preserve_c;
            end
            // class at the top of the word
            4'h6: begin
                rd_word[SYN_EC_LSB +: 6] = syndrome.ec;
                rd_word[SYN_LEVEL_LSB +: 2] = syndrome.level;
            end
            4'h7: rd_word[IRQ_W-1:0] = int_status;
            4'h8: rd_word[IRQ_W-1:0] = int_mask;
            default: rd_word = '0;
        endcase
    end

    // read data and error answer, captured in setup
    // both hold outside setup, so a
    // master may sample them late
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            // a trapped limit read answers zero with error
            prdata <= (is_limit && cur_off) ? '0 : rd_word;
            pslverr <= (sel == 4'h0) || (is_limit && cur_off);
        end
    end

    // limit registers, written only when not trapped
    // reset to 0xf: full implemented
    // length at every level
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int l = 1; l < LVL_N; l++) begin
                limit[l] <= LIMIT_RESET;
            end
        end else if (wr_ok && is_limit) begin
            limit[sel[1:0]] <= pwdata[CODE_W-1:0];  // stored as written
        end
    end

    // control word split into its fields;
    // the gap at [3:2] is not stored
    wire ctrl_s ctrl_wr;
    assign ctrl_wr = '{
        fill_zero: pwdata[CTRL_FILL_ZERO_BIT],
        fp_off: pwdata[CTRL_FP_OFF_LSB +: LVL_N],
        narrow: pwdata[CTRL_NARROW_LSB +: LVL_N],
        vec_off: pwdata[CTRL_VEC_OFF_LSB +: LVL_N],
        level: pwdata[CTRL_LEVEL_LSB +: 2]
    };

    // control and mask registers
    // mask resets to zero: no
    // interrupt until software opts in
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl <= '0;
            int_mask <= MASK_RESET;
        end else begin
            // fields land as one word
            if (wr_ok && sel == 4'h4) begin
                ctrl <= ctrl_wr;
            end
            // mask bits per event
            if (wr_ok && sel == 4'h8) begin
                int_mask <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // syndrome record on each trap
    // a later trap overwrites it;
    // only the latest is kept
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            syndrome <= '0;
        end else if (trap_evt) begin
            syndrome.ec <= EC_VECTOR_TRAP;
            syndrome.level <= ctrl.level;
        end
    end

    // sticky events: a set in the clearing cycle wins
    // eff_prev resets to the maximum,
    // the reset code, so leaving reset
    // raises no length event
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            int_status <= '0;
            eff_prev <= CODE_W'(MAX_CODE);
        end else begin
            int_status <= (int_status & ~w1c) | evt;
            eff_prev <= next_eff;
        end
    end

endmodule : vector_length_limiter
`default_nettype wire

// [hdl/vlen_pkg.sv]
/*
 package for the vector length limiter: register byte offsets,
 field positions, reset values, exception class code and the
 packed control record.
 assumes a 32-bit apb register bus and four exception levels.
*/
package vlen_pkg;

    // code widths
    localparam int CODE_W = 4;            // width of a length_code
    localparam int GRAN_N = 16;           // 128-bit granules at most
    localparam int LVL_N = 4;             // exception levels 0..3
    localparam int GRAN_BITS = 128;       // bits per length step

    // register byte offsets
    localparam logic [7:0] OFS_LIMIT_EL1 = 8'h00;
    localparam logic [7:0] OFS_LIMIT_EL2 = 8'h04;
    localparam logic [7:0] OFS_LIMIT_EL3 = 8'h08;
    localparam logic [7:0] OFS_CTRL = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_SYNDROME = 8'h14;
    localparam logic [7:0] OFS_INT_STATUS = 8'h18;
    localparam logic [7:0] OFS_INT_MASK = 8'h1c;

    // field positions
    localparam int CTRL_LEVEL_LSB = 0;    // current level, 2 bits
    localparam int CTRL_VEC_OFF_LSB = 4;  // vector disabled/trapped
    localparam int CTRL_NARROW_LSB = 8;   // level in 32-bit state
    localparam int CTRL_FP_OFF_LSB = 12;  // fp disabled/trapped
    localparam int CTRL_FILL_ZERO_BIT = 16;
    localparam int STAT_PRESERVE_BIT = 8; // eff code sits in [3:0]
    localparam int SYN_EC_LSB = 26;       // exception_class_field
    localparam int SYN_LEVEL_LSB = 0;
    localparam int IRQ_TRAP_BIT = 0;
    localparam int IRQ_LEN_BIT = 1;
    localparam int IRQ_W = 2;

    // reset values
    localparam logic [CODE_W-1:0] LIMIT_RESET = 4'hf;
    localparam logic [IRQ_W-1:0] MASK_RESET = 2'h0;

    // syndrome class for a trapped vector or limit access
    localparam logic [5:0] EC_VECTOR_TRAP = 6'h19;

    // control record held in the control register
    typedef struct packed {
        logic fill_zero;                  // refill policy
        logic [LVL_N-1:0] fp_off;
        logic [LVL_N-1:0] narrow;
        logic [LVL_N-1:0] vec_off;
        logic [1:0] level;
    } ctrl_s;

    // syndrome record
    typedef struct packed {
        logic [5:0] ec;
        logic [1:0] level;
    } syndrome_s;

endpackage : vlen_pkg

// [verification/tb.sv]
/*
 self-checking bench for the vector length limiter: apb master,
 random limits and level controls against an integer model.
 assumes default parameters: maximum code 15, no optional lengths.
*/
`timescale 1ns/100ps
`default_nettype none

module tb;
    import vlen_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, vec_insn_attempt = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, state_preserve, irq;
    logic [3:0] eff_length_code;
    logic [15:0] gran_enable, gran_zero;
    int bad_count = 0, tests_run = 0, n;
    int lim [4]; // model of the limits, index is level
    int lvl, vo, nr, fo, fz; // model of the control fields
    always #25 sys_clk = ~sys_clk;

    vector_length_limiter u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .vec_insn_attempt(vec_insn_attempt),
        .eff_length_code(eff_length_code), .gran_enable(gran_enable), .gran_zero(gran_zero),
        .state_preserve(state_preserve), .irq(irq));

    task complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // one apb transfer; waits for pready, takes data at that edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        n = 0;
        @(posedge sys_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) bad_count++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task set_ctrl;
        apb(1'b1, OFS_CTRL, {15'h0, fz[0], fo[3:0], nr[3:0], vo[3:0], 2'h0, lvl[1:0]});
    endtask : set_ctrl

    task pulse_attempt;
        @(posedge sys_clk) vec_insn_attempt <= 1'b1;
        @(posedge sys_clk) vec_insn_attempt <= 1'b0;
        #1;
    endtask : pulse_attempt

    // supported codes are 15 and those below it that are a power of two minus one
    function automatic int rnd(int c);
        if (c >= 15) return 15;
        if (c >= 7) return 7;
        if (c >= 3) return 3;
        return (c >= 1) ? 1 : 0;
    endfunction : rnd

    // unusable levels count as code 0, lowest limit wins
    function automatic int eff();
        int m;
        m = 15;
        for (int l = (lvl > 1 ? lvl : 1); l < 4; l++)
            m = (((vo | nr) >> l) & 1) ? 0 : (rnd(lim[l]) < m ? rnd(lim[l]) : m);
        return m;
    endfunction : eff

    function automatic int pres();
        for (int l = 0; l < lvl; l++)
            if (!(((fo >> l) & 1) && (((vo | nr) >> l) & 1))) return 0;
        return 1;
    endfunction : pres

    // watchdog, far beyond the expected run
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        complete_run();
    end

    initial begin
        void'($urandom(1));
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        #1 chk("eff reset", 32'(eff_length_code), 32'd15);
        chk("gran reset", 32'(gran_enable), 32'hffff);
        apb(1'b0, OFS_LIMIT_EL1, 32'h0);
        chk("limit reset", rd, 32'(LIMIT_RESET));
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped", {rd[30:0], er}, 32'h1);
        for (int i = 0; i < 16; i++) begin
            {lvl, vo, nr, fo, fz} = '0;
            set_ctrl();
            for (int l = 1; l < 4; l++) begin
                lim[l] = $urandom_range(15, 0);
                apb(1'b1, 8'(4 * (l - 1)), lim[l]);
            end
            for (int l = 1; l < 4; l++) begin
                apb(1'b0, 8'(4 * (l - 1)), 32'h0);
                chk("limit readback", rd, lim[l]);
            end
            lvl = $urandom_range(3, 0);
            vo = $urandom_range(15, 0) & $urandom_range(15, 0);
            nr = $urandom_range(15, 0) & $urandom_range(15, 0);
            fo = $urandom_range(15, 0);
            set_ctrl();
            repeat (3) @(posedge sys_clk);
            chk("eff", 32'(eff_length_code), eff());
            chk("gran", 32'(gran_enable), (2 << eff()) - 1);
            apb(1'b0, OFS_STATUS, 32'h0);
            chk("status", rd, eff() | (pres() << 8));
            chk("preserve", 32'(state_preserve), pres());
        end
        // shrink then regrow with zero fill
        {lvl, vo, nr, fo, fz} = {32'd1, 32'd0, 32'd0, 32'd0, 32'd1};
        set_ctrl();
        apb(1'b1, OFS_LIMIT_EL2, 32'hf);
        apb(1'b1, OFS_LIMIT_EL3, 32'hf);
        apb(1'b1, OFS_LIMIT_EL1, 32'h0);
        #1 chk("eff after write", 32'(eff_length_code), 32'h0);
        apb(1'b1, OFS_LIMIT_EL1, 32'hf);
        n = 0;
        while (gran_zero === 16'h0 && n < 6) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk("gran zero", 32'(gran_zero), 32'hfffe);
        // trapped vector use at level 1
        apb(1'b1, OFS_INT_STATUS, 32'h3);
        apb(1'b1, OFS_INT_MASK, 32'h1);
        {lvl, vo, nr, fo, fz} = {32'd1, 32'd2, 32'd0, 32'd0, 32'd0};
        set_ctrl();
        #1 chk("irq idle", 32'(irq), 32'h0);
        pulse_attempt();
        chk("irq trap", 32'(irq), 32'h1);
        apb(1'b0, OFS_SYNDROME, 32'h0);
        chk("syndrome", rd, {EC_VECTOR_TRAP, 24'h0, 2'h1});
        apb(1'b0, OFS_LIMIT_EL1, 32'h0);
        chk("limit trapped", {rd[30:0], er}, 32'h1);
        apb(1'b1, OFS_INT_STATUS, 32'h1);
        #1 chk("irq cleared", 32'(irq), 32'h0);
        apb(1'b1, OFS_INT_MASK, 32'h0);
        pulse_attempt();
        chk("irq masked", 32'(irq), 32'h0);
        apb(1'b0, OFS_INT_STATUS, 32'h0);
        chk("trap sticky", 32'(rd[IRQ_W-1:0]), 32'h3);
        // regrow with zero fill off: no zero pulse
        {lvl, vo, nr, fo, fz} = {32'd1, 32'd0, 32'd0, 32'd0, 32'd0};
        set_ctrl();
        repeat (3) begin
            @(posedge sys_clk);
            #1 chk("no zero fill", 32'(gran_zero), 32'h0);
        end
        chk("gran regrown", 32'(gran_enable), 32'hffff);
        complete_run();
    end
endmodule : tb

`default_nettype wire

// [verification/vlen_monitor.sv]
/*
 port checker for the vector length limiter: apb answer timing,
 effective length legality and granule mask behaviour.
 assumes binding into vector_length_limiter, one clock.
*/
`timescale 1ns/100ps
`default_nettype none

module vlen_monitor #(
    parameter int MAX_CODE = 15,
    parameter logic [15:0] OPT_MASK = 16'h0000
) (
    // clock, reset and apb
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // core side
    input wire logic [vlen_pkg::CODE_W-1:0] eff_length_code,
    input wire logic [vlen_pkg::GRAN_N-1:0] gran_enable,
    input wire logic [vlen_pkg::GRAN_N-1:0] gran_zero
);
    import vlen_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic setup_q; // last cycle was an apb setup cycle
    // granules below (code plus one) steps; 17 bits so code 15 fits
    wire logic [16:0] full_mask = (17'h2 << eff_length_code) - 17'h1;
    // remember setup cycles, read data may only move after one
    always_ff @(posedge sys_clk) begin
        setup_q <= rst_n && psel && !penable;
    end
    sequence s_steady;
        $stable(eff_length_code);
    endsequence
    sequence s_setup_bad;
        psel && !penable && paddr > OFS_INT_MASK;
    endsequence
    property p_pready;
        psel && penable |-> pready;
    endproperty
    property p_unmapped;
        s_setup_bad |=> pslverr && prdata == 32'h0;
    endproperty
    property p_hold;
        !setup_q |-> $stable(prdata) && $stable(pslverr);
    endproperty
    property p_cap;
        eff_length_code <= MAX_CODE;
    endproperty
    property p_supported;
        eff_length_code == MAX_CODE || OPT_MASK[eff_length_code]
            || ((eff_length_code + 4'h1) & eff_length_code) == 4'h0;
    endproperty
    property p_gran_follow;
        s_steady |-> gran_enable == full_mask[15:0];
    endproperty
    property p_zero_sub;
        gran_zero != 16'h0 |-> (gran_zero & ~gran_enable) == 16'h0;
    endproperty
    property p_zero_pulse;
        gran_zero != 16'h0 |=> gran_zero == 16'h0;
    endproperty
    a_pready: assert property (p_pready) else $error("pready missing in access");
    a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
    a_hold: assert property (p_hold) else $error("read data moved");
    a_cap: assert property (p_cap) else $error("length above maximum");
    a_supported: assert property (p_supported) else $error("unsupported length");
    a_gran_follow: assert property (p_gran_follow) else $error("granule mask wrong");
    a_zero_sub: assert property (p_zero_sub) else $error("zero on hidden granule");
    a_zero_pulse: assert property (p_zero_pulse) else $error("zero pulse too long");
endmodule : vlen_monitor

bind vector_length_limiter vlen_monitor #(.MAX_CODE(MAX_CODE), .OPT_MASK(OPT_MASK)) u_mon (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .eff_length_code(eff_length_code),
    .gran_enable(gran_enable), .gran_zero(gran_zero));

`default_nettype wire
